// File: rtl/rbv_reset_ctrl.sv
// reset collection, reset state control and boot vector select
`timescale 1ns/100ps
`default_nettype none
`include "rbv_consts.svh"
module rbv_reset_ctrl (
  // clock and asynchronous reset (power-on level)
  input  wire logic                         core_clk,
  input  wire logic                         resetn,
  // reset causes, asynchronous levels, active high
  input  wire logic [`RBV_NUM_CAUSES-1:0]   cause_in,
  // external reset pin, open-drain (sensed, driven)
  input  wire logic                         reset_pin_low_in,
  output logic                              reset_pin_low_out,
  output logic                              reset_pin_low_oe_n,
  // flash boot signature byte
  input  wire logic [7:0]                   boot_sig_byte,
  // core control
  output logic                              core_halt,
  output logic                              core_start,
  output rbv_pkg::rbv_addr_t                start_vector,
  output rbv_pkg::rbv_addr_t                program_counter,
  // reset to module registers
  output logic                              sys_reset,
  output logic                              por_reset,
  output logic                              ram_write_block,
  // port reset state
  output logic [7:0]                        port_latch_rst,
  output logic                              port_open_drain,
  output logic                              weak_pullup_en,
  // interrupts and timers
  output logic                              irq_disable,
  output logic                              timer_disable,
  // watchdog_unit and clock defaults
  output logic                              watchdog_unit_en,
  output logic [2:0]                        watchdog_unit_tmo,
  output logic [1:0]                        clk_src_sel,
  output logic [2:0]                        clk_div_sel,
  // last reset cause flags
  output logic [`RBV_NUM_CAUSES-1:0]        last_cause
);
  import rbv_pkg::*;

  // ==========================================================
  // reset release synchroniser
  // ==========================================================
  logic rst_meta;   // first stage, read only by rst_sync
  logic rst_sync;   // released reset, reset active when low

  // release the asynchronous power reset through two flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================
  // cause synchronisers
  // ==========================================================
  logic [`RBV_NUM_CAUSES-1:0] cause_meta;  // first stages
  logic [`RBV_NUM_CAUSES-1:0] cause_sync;  // synchronised causes
  logic                       pin_meta;    // pin first stage
  logic                       pin_sync;    // pin synchronised
  logic [1:0]                 self_drive_d; // own drive, pin-sync aligned

  // two flops per cause; the pin has its own pair below
  genvar gi;
  generate
    for (gi = 0; gi < `RBV_NUM_CAUSES; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge core_clk or negedge rst_sync)
      begin
        if (!rst_sync)
        begin
          cause_meta[gi] <= 1'b0;
          cause_sync[gi] <= 1'b0;
        end
        else
        begin
          cause_meta[gi] <= cause_in[gi];
          cause_sync[gi] <= cause_meta[gi];
        end
      end
    end
  endgenerate

  // synchronise the sensed reset pin level (active low pin)
  always_ff @(posedge core_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      self_drive_d <= 2'h3;
    end
    else
    begin
      pin_meta <= !reset_pin_low_in;
      pin_sync <= pin_meta;
      self_drive_d <= {self_drive_d[0], !reset_pin_low_oe_n};
    end
  end

  // ==========================================================
  // cause decode
  // ==========================================================
  logic [`RBV_NUM_CAUSES-1:0] cause_eff;   // all causes, pin merged
  logic                       any_cause;   // any cause active
  logic                       drive_cause; // cause that drives pin
  logic                       pin_self;    // pin low from own drive

  // own drive shows on pin_sync two edges late; mask it that long
  assign pin_self = self_drive_d[1];

  // merge pin into its cause slot
  assign cause_eff = cause_sync
                     | ({{(`RBV_NUM_CAUSES-1){1'b0}},
                         (pin_sync && !pin_self)} << `RBV_C_PIN);
  assign any_cause = |cause_eff;

  // only power-on and supply monitor drive the pin
  // watchdog reset leaves the pin alone
  assign drive_cause = cause_eff[`RBV_C_POR]
                       || cause_eff[`RBV_C_SUPPLY];

  // ==========================================================
  // reset state machine
  // ==========================================================
  rbv_state_t state;       // current state
  rbv_state_t next_state;  // next state
  logic       pin_drive;   // drive pin low
  logic       next_pin_drive;

  // stay in reset until every cause released
  always_comb
  begin
    next_state     = state;
    next_pin_drive = pin_drive;
    case (state)
      RBV_ST_RESET:
      begin
        // latch drive request while any power cause seen
        if (drive_cause)
          next_pin_drive = 1'b1;
        if (!any_cause)
        begin
          next_state     = RBV_ST_FETCH;
          next_pin_drive = 1'b0;
        end
      end
      RBV_ST_FETCH:
      begin
        // one cycle to start the core at the vector
        next_state = any_cause ? RBV_ST_RESET : RBV_ST_RUN;
        next_pin_drive = drive_cause;
      end
      RBV_ST_RUN:
      begin
        // any cause re-enters the reset state
        if (any_cause)
        begin
          next_state     = RBV_ST_RESET;
          next_pin_drive = drive_cause;
        end
      end
      default:
      begin
        next_state     = RBV_ST_RESET;
        next_pin_drive = 1'b1;
      end
    endcase
  end

  // state register; power reset starts in reset with pin driven
  always_ff @(posedge core_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state     <= RBV_ST_RESET;
      pin_drive <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      pin_drive <= next_pin_drive;
    end
  end

  // ==========================================================
  // boot vector select
  // ==========================================================
  logic      boot_present;  // signature marks bootloader
  rbv_addr_t next_vector;   // vector chosen for this exit

  // signature
  assign boot_present = boot_sig_byte == `RBV_BOOT_SIG;
  // bootloader at the last flash page or normal vector
  assign next_vector = boot_present ? `RBV_BOOT_VEC
                                    : `RBV_RESET_VEC;

  // ==========================================================
  // outputs from flops
  // ==========================================================
  logic in_reset;  // reset state held
  assign in_reset = state == RBV_ST_RESET;

  // registered outputs, all defined from power reset
  always_ff @(posedge core_clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      core_halt         <= 1'b1;
      core_start        <= 1'b0;
      start_vector      <= `RBV_RESET_VEC;
      program_counter   <= `RBV_PC_RST;
      sys_reset         <= 1'b1;
      por_reset         <= 1'b1;
      ram_write_block   <= 1'b1;
      last_cause        <= '0;
    end
    else
    begin
      // halt core while in reset
      core_halt       <= next_state != RBV_ST_RUN;
      // register defaults during reset
      sys_reset       <= next_state == RBV_ST_RESET;
      // power-on-only bits reset only by power-on
      por_reset       <= next_state == RBV_ST_RESET
                         && cause_eff[`RBV_C_POR];
      // block ram writes, contents kept
      ram_write_block <= next_state == RBV_ST_RESET;
      // start pulse and fetch address on exit
      core_start      <= next_state == RBV_ST_FETCH;
      if (next_state == RBV_ST_FETCH)
      begin
        start_vector    <= next_vector;
        program_counter <= `RBV_PC_RST;
      end
      // remember the causes of the last reset cycle with any cause active
      if (in_reset && any_cause)
        last_cause <= cause_eff;
    end
  end

  // ==========================================================
  // reset-state and default output levels
  // ==========================================================
  // pin open-drain low drive (oe low = driving)
  assign reset_pin_low_out  = 1'b0;
  assign reset_pin_low_oe_n = !pin_drive;
  // port latches one, open-drain while in reset
  assign port_latch_rst     = `RBV_PORT_RST;
  assign port_open_drain    = sys_reset;
  // pull-ups always on, in and after reset
  assign weak_pullup_en     = 1'b1;
  // interrupts and timers off in reset
  assign irq_disable        = sys_reset;
  assign timer_disable      = sys_reset;
  // watchdog enabled at max timeout after reset
  assign watchdog_unit_en   = !sys_reset;
  assign watchdog_unit_tmo  = `RBV_WDOG_TMO_MAX;
  // low-power oscillator divided by eight
  assign clk_src_sel        = `RBV_CLKSEL_LPOSC;
  assign clk_div_sel        = `RBV_CLKDIV_8;

  // ==========================================================
  // checks
  // ==========================================================
  AST_HALT_IN_RESET: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    in_reset |=> core_halt)
    else $error("core not halted in reset");
  AST_ENTER_ON_CAUSE: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (state == RBV_ST_RUN && any_cause) |=> in_reset)
    else $error("cause did not enter reset");
  AST_PIN_DRIVE: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (in_reset && drive_cause) |=> !reset_pin_low_oe_n)
    else $error("pin not driven for power cause");
  AST_WDOG_NO_PIN: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (state == RBV_ST_RUN && cause_eff == (9'h001 << `RBV_C_WDOG))
    |=> reset_pin_low_oe_n)
    else $error("watchdog reset drove the pin");
  AST_BOOT_VEC: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (next_state == RBV_ST_FETCH && boot_present)
    |=> start_vector == `RBV_BOOT_VEC && core_start)
    else $error("boot vector not taken");
  AST_NORM_VEC: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (next_state == RBV_ST_FETCH && !boot_present)
    |=> start_vector == `RBV_RESET_VEC && program_counter == 16'h0000)
    else $error("normal vector not taken");
  AST_IRQ_OFF: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    $rose(sys_reset) |-> irq_disable && timer_disable && core_halt)
    else $error("irq or timer enabled in reset");
  AST_WDOG_ON: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    ($fell(sys_reset) && !any_cause) |-> watchdog_unit_en ##1 !core_halt)
    else $error("watchdog not enabled on exit");
  AST_HOLD: assert property (
    @(posedge core_clk) disable iff (!rst_sync)
    (in_reset && any_cause) |=> in_reset)
    else $error("reset left with cause active");
endmodule
`default_nettype wire

// File: rtl/rbv_consts.svh
// constants for the reset and boot vector controller
`ifndef RBV_CONSTS_SVH
`define RBV_CONSTS_SVH
// number of reset causes
`define RBV_NUM_CAUSES      9
// cause bit positions
`define RBV_C_POR           0
`define RBV_C_PIN           1
`define RBV_C_CMP           2
`define RBV_C_SW            3
`define RBV_C_SUPPLY        4
`define RBV_C_WDOG          5
`define RBV_C_MISSCLK       6
`define RBV_C_FLASH         7
`define RBV_C_TIMEKEEP      8
// boot signature marking a bootloader present
`define RBV_BOOT_SIG        8'hA5
// normal reset vector
`define RBV_RESET_VEC       16'h0000
// default bootloader vector (start of last flash page)
`define RBV_BOOT_VEC        16'hFC00
// program counter reset value
`define RBV_PC_RST          16'h0000
// clock source and divider codes out of reset
`define RBV_CLKSEL_LPOSC    2'h0
`define RBV_CLKDIV_8        3'h3
// watchdog default (maximum) timeout code
`define RBV_WDOG_TMO_MAX    3'h7
// port latch reset value
`define RBV_PORT_RST        8'hFF
`endif

// File: rtl/rbv_pkg.sv
// types for the reset and boot vector controller
package rbv_pkg;
  // controller states
  typedef enum logic [1:0] {
    RBV_ST_RESET,
    RBV_ST_FETCH,
    RBV_ST_RUN
  } rbv_state_t;
  // vector and program counter address
  typedef logic [15:0] rbv_addr_t;
endpackage

// File: testbench/rbv_pin_model.sv
// open-drain reset pin model: pull-up, device drive, external pull
`timescale 1ns/100ps
`default_nettype none
module rbv_pin_model (
  // device side of the pin
  input  wire logic pin_drive_out,
  input  wire logic pin_oe_n,
  // external party that may pull the pin low
  input  wire logic ext_pull_low,
  // level seen on the wire
  output logic      pin_level
);
  // ==========================================================
  // wire level
  // wired-and: the pull-up wins only when nobody pulls low, so a
  // released pin never shows a stale value
  assign pin_level = ((!pin_oe_n && !pin_drive_out) || ext_pull_low)
                     ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: testbench/rbv_reset_ctrl_tb.sv
// self-checking bench for the reset and boot vector controller
`timescale 1ns/100ps
`default_nettype none
`include "rbv_consts.svh"
module rbv_reset_ctrl_tb;
  import rbv_pkg::*;
  // ==========================================================
  // signals
  logic                       core_clk;      // 40 MHz clock
  logic                       resetn;        // power reset, low active
  logic [`RBV_NUM_CAUSES-1:0] cause_in;      // reset cause levels
  logic                       ext_low;       // external pull on the pin
  logic [7:0]                 boot_sig_byte; // flash signature byte
  logic                       pin_in, pin_out, pin_oe_n;
  logic                       core_halt, core_start, sys_reset, por_reset;
  logic                       ram_write_block, port_open_drain;
  logic                       weak_pullup_en, irq_disable, timer_disable;
  logic                       watchdog_unit_en;
  logic [2:0]                 watchdog_unit_tmo, clk_div_sel;
  logic [1:0]                 clk_src_sel;
  logic [7:0]                 port_latch_rst;
  rbv_addr_t                  start_vector, program_counter;
  logic [`RBV_NUM_CAUSES-1:0] last_cause;
  int                         mismatches;    // failed comparisons
  int                         num_checks;    // comparisons made
  logic [7:0]                 sigs [9];      // signature per cause
  // ==========================================================
  // design and far side
  rbv_reset_ctrl dut (.core_clk(core_clk), .resetn(resetn),
    .cause_in(cause_in), .reset_pin_low_in(pin_in),
    .reset_pin_low_out(pin_out), .reset_pin_low_oe_n(pin_oe_n),
    .boot_sig_byte(boot_sig_byte), .core_halt(core_halt),
    .core_start(core_start), .start_vector(start_vector),
    .program_counter(program_counter), .sys_reset(sys_reset),
    .por_reset(por_reset), .ram_write_block(ram_write_block),
    .port_latch_rst(port_latch_rst), .port_open_drain(port_open_drain),
    .weak_pullup_en(weak_pullup_en), .irq_disable(irq_disable),
    .timer_disable(timer_disable), .watchdog_unit_en(watchdog_unit_en),
    .watchdog_unit_tmo(watchdog_unit_tmo), .clk_src_sel(clk_src_sel),
    .clk_div_sel(clk_div_sel), .last_cause(last_cause));
  rbv_pin_model pin (.pin_drive_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_pull_low(ext_low), .pin_level(pin_in));
  // ==========================================================
  // clock
  initial core_clk = 1'b0;
  // half period of 12.5 ns
  always #12.5 core_clk = ~core_clk;
  // ==========================================================
  // helpers
  // compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // step n edges, then settle 2 ns past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // outputs while the reset state is held
  task automatic in_reset(input logic drive_n, input logic por);
    check(core_halt, 1'b1);
    check(core_start, 1'b0);
    check(sys_reset, 1'b1);
    check(por_reset, por);
    check(port_latch_rst, 8'hFF);
    check(port_open_drain, 1'b1);
    check(weak_pullup_en, 1'b1);
    check(irq_disable, 1'b1);
    check(timer_disable, 1'b1);
    check(ram_write_block, 1'b1);
    check(pin_oe_n, drive_n);
    check(pin_out, 1'b0);
  endtask
  // wait for the exit pulse and judge the first run cycle
  task automatic exit_reset();
    int i;
    i = 0;
    while (core_start !== 1'b1 && i < 20)
    begin
      tick(1);
      i++;
    end
    check(core_start, 1'b1);
    check(start_vector, (boot_sig_byte === `RBV_BOOT_SIG)
      ? `RBV_BOOT_VEC : `RBV_RESET_VEC);
    check(program_counter, `RBV_PC_RST);
    tick(1);
    check(core_halt, 1'b0);
    check(sys_reset, 1'b0);
    check(weak_pullup_en, 1'b1);
    check(irq_disable, 1'b0);
    check(timer_disable, 1'b0);
    check(port_open_drain, 1'b0);
    check(ram_write_block, 1'b0);
    check(por_reset, 1'b0);
    check(pin_oe_n, 1'b1);
    check(watchdog_unit_en, 1'b1);
    check(watchdog_unit_tmo, `RBV_WDOG_TMO_MAX);
    check(clk_src_sel, `RBV_CLKSEL_LPOSC);
    check(clk_div_sel, `RBV_CLKDIV_8);
    // the released pin must not read back as a fresh cause
    tick(2);
    check(core_halt, 1'b0);
    check(sys_reset, 1'b0);
  endtask
  // ==========================================================
  // scenarios
  // power reset with a given signature
  task automatic power_on(input logic [7:0] sig);
    resetn = 1'b0;
    boot_sig_byte = sig;
    tick(5);
    in_reset(1'b0, 1'b1);
    resetn = 1'b1;
    exit_reset();
  endtask
  // every cause in turn; bit 1 is the external pin
  task automatic cause_sweep();
    for (int b = 0; b < 9; b++)
    begin
      boot_sig_byte = sigs[b];
      if (b == 1)
        ext_low = 1'b1;
      else
        cause_in[b] = 1'b1;
      tick(5);
      in_reset((b == 0 || b == 4) ? 1'b0 : 1'b1, b == 0);
      tick(3);
      ext_low = 1'b0;
      cause_in = '0;
      exit_reset();
      check(last_cause, 9'h001 << b);
    end
  endtask
  // two causes overlap; exit only when both are gone
  task automatic overlap();
    cause_in[3] = 1'b1;
    cause_in[6] = 1'b1;
    tick(5);
    cause_in[3] = 1'b0;
    tick(8);
    check(core_halt, 1'b1);
    check(core_start, 1'b0);
    cause_in[6] = 1'b0;
    exit_reset();
  endtask
  // ==========================================================
  // verdict
  task automatic complete_run();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    cause_in = '0;
    ext_low = 1'b0;
    resetn = 1'b0;
    boot_sig_byte = 8'hA5;
    sigs = '{8'hA5, 8'h00, 8'hA4, 8'hFF, 8'h25,
             8'hA5, 8'h5A, 8'hA5, 8'hE5};
    power_on(8'hA5);
    cause_sweep();
    overlap();
    tick(3);
    power_on(8'h00);
    complete_run();
  end
  // watchdog: the tests need well under 1000 cycles
  initial
  begin
    #(25 * 3000);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
